// *** dmba_pkg.sv ***
// Package: constants and types for the data memory bus arbiter
package dmba_pkg;

  // Requester indices
  localparam int DMBA_N_REQ = 3;
  localparam logic [1:0] DMBA_REQ_CORE  = 2'h0;
  localparam logic [1:0] DMBA_REQ_DMA   = 2'h1;
  localparam logic [1:0] DMBA_REQ_DEBUG = 2'h2;

  // Priority control encodings
  localparam logic [15:0] DMBA_PRIO_DEFAULT   = 16'h0000;
  localparam logic [15:0] DMBA_PRIO_DMA_RAISE = 16'h0020;
  localparam logic [15:0] DMBA_PRIO_RESET     = 16'h0000;

  // Priority slots, zero is highest
  localparam logic [2:0] DMBA_SLOT_ZERO  = 3'h0;
  localparam logic [2:0] DMBA_SLOT_ONE   = 3'h1;
  localparam logic [2:0] DMBA_SLOT_THREE = 3'h3;
  localparam logic [2:0] DMBA_SLOT_FOUR  = 3'h4;

  typedef enum logic [0:0] {
    DMBA_IDLE = 1'b0,
    DMBA_BUSY = 1'b1
  } dmba_state_t;

endpackage : dmba_pkg

// *** dmba_slot_if.sv ***
// Interface: per-requester priority slot bundle between arbiter modules
`timescale 1ns/100ps
interface dmba_slot_if;
  import dmba_pkg::*;
  logic [2:0] coreSlot;
  logic [2:0] dmaSlot;
  logic [2:0] debugSlot;
  modport map (output coreSlot, output dmaSlot, output debugSlot);
  modport arb (input coreSlot, input dmaSlot, input debugSlot);
endinterface : dmba_slot_if

// *** dmba_slot_map.sv ***
// Slot map: turns the priority control value into a slot per requester
`timescale 1ns/100ps
module dmba_slot_map
  import dmba_pkg::*;
(
  input  wire logic [15:0] prioCtrl,
  dmba_slot_if.map         slots
);

  // Debug master always stays lowest; raising DMA keeps core right below it
  always_comb begin
    if (prioCtrl == DMBA_PRIO_DMA_RAISE) begin
      slots.dmaSlot  = DMBA_SLOT_ZERO;
      slots.coreSlot = DMBA_SLOT_ONE;
    end else begin
      // Reserved encodings fall back to the default scheme
      slots.coreSlot = DMBA_SLOT_ZERO;
      slots.dmaSlot  = DMBA_SLOT_THREE;
    end
    slots.debugSlot = DMBA_SLOT_FOUR;
  end

endmodule // dmba_slot_map

// *** dmba_arbiter.sv ***
// Top: data memory bus arbiter for core, DMA and debug master
`timescale 1ns/100ps

module dmba_arbiter
  import dmba_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [15:0]           prioCtrl,
  input  wire logic                  prioWrite,
  input  wire logic [DMBA_N_REQ-1:0] req,
  input  wire logic [DMBA_N_REQ-1:0] accessDone,
  output logic      [DMBA_N_REQ-1:0] grant,
  output logic      [DMBA_N_REQ-1:0] stall,
  output logic      [15:0]           prioActive
);

  // ---------------------------------------------------------------
  // Priority control register
  // ---------------------------------------------------------------
  logic [15:0] prio_r;
  logic [15:0] prio_nxt;

  // Written at any time; the grant logic uses it only at a new decision
  always_comb begin
    prio_nxt = prio_r;
    if (prioWrite) begin
      prio_nxt = prioCtrl;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prio_r <= DMBA_PRIO_RESET;
    end else begin
      prio_r <= prio_nxt;
    end
  end

  assign prioActive = prio_r;

  // A write lands on the next edge; without one the value must not drift
  a_prio_written: assert property (@(posedge clk) disable iff (!arst_n)
    prioWrite |=> prioActive == $past(prioCtrl))
    else $error("priority write not taken");

  a_prio_kept: assert property (@(posedge clk) disable iff (!arst_n)
    !prioWrite |=> $stable(prioActive))
    else $error("priority value changed without a write");

  // ---------------------------------------------------------------
  // Slot map
  // ---------------------------------------------------------------
  dmba_slot_if slotBus ();

  dmba_slot_map u_slot_map (
    .prioCtrl (prio_r),
    .slots    (slotBus.map)
  );

  // ---------------------------------------------------------------
  // Winner selection
  // ---------------------------------------------------------------
  logic [DMBA_N_REQ-1:0] winner;
  logic [2:0]            bestSlot;

  // Lowest slot number among active requests wins
  always_comb begin
    winner   = '0;
    bestSlot = 3'h7;
    if (req[DMBA_REQ_CORE] && slotBus.coreSlot < bestSlot) begin
      bestSlot = slotBus.coreSlot;
      winner   = 3'h1;
    end
    if (req[DMBA_REQ_DMA] && slotBus.dmaSlot < bestSlot) begin
      bestSlot = slotBus.dmaSlot;
      winner   = 3'h2;
    end
    if (req[DMBA_REQ_DEBUG] && slotBus.debugSlot < bestSlot) begin
      bestSlot = slotBus.debugSlot;
      winner   = 3'h4;
    end
  end

  // ---------------------------------------------------------------
  // Grant state machine
  // ---------------------------------------------------------------
  dmba_state_t           state_r;
  dmba_state_t           state_nxt;
  logic [DMBA_N_REQ-1:0] owner_r;
  logic [DMBA_N_REQ-1:0] owner_nxt;

  // Grant is held until the owner ends its access, so a priority change
  // never splits a transfer; losers wait for the next decision
  always_comb begin
    state_nxt = state_r;
    owner_nxt = owner_r;
    case (state_r)
      DMBA_IDLE: begin
        if (|winner) begin
          state_nxt = DMBA_BUSY;
          owner_nxt = winner;
        end
      end
      DMBA_BUSY: begin
        if (|(owner_r & accessDone)) begin
          state_nxt = DMBA_IDLE;
          owner_nxt = '0;
        end
      end
      default: begin
        state_nxt = DMBA_IDLE;
        owner_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DMBA_IDLE;
      owner_r <= '0;
    end else begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
    end
  end

  // Stalled requesters must hold their request and attributes
  assign grant = owner_r;
  assign stall = req & ~owner_r;

  // ---------------------------------------------------------------
  // Grant and priority order checks
  // ---------------------------------------------------------------
  // Decisions are judged one edge after the idle cycle that takes them,
  // against the priority value that was loaded at that idle cycle

  // At most one owner may drive the data bus
  a_grant_onehot: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot0(grant))
    else $error("more than one grant");

  // An owner keeps the bus until its own access ends
  a_grant_held: assert property (@(posedge clk) disable iff (!arst_n)
    (|grant && !(|(grant & accessDone))) |=> grant == $past(grant))
    else $error("grant dropped before access done");

  // The bus falls idle for one cycle after every completed access
  a_grant_gap: assert property (@(posedge clk) disable iff (!arst_n)
    (|(grant & accessDone)) |=> grant == 3'h0)
    else $error("grant not released after access done");

  // A grant goes only to a master that was asking
  a_grant_to_req: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE) |=> (grant & ~$past(req)) == 3'h0)
    else $error("grant given without a request");

  // A free bus is handed out on the very next edge
  a_idle_grants: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && |req) |=> |grant)
    else $error("request left unserved while idle");

  // Losers see stall for as long as they ask and do not own
  a_stall_losers: assert property (@(posedge clk) disable iff (!arst_n)
    (|grant) |-> (stall == (req & ~grant)))
    else $error("loser not stalled");

  // Default scheme: the core outranks every other master
  a_core_first: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && req[DMBA_REQ_CORE] && prio_r != DMBA_PRIO_DMA_RAISE)
    |=> grant == 3'h1)
    else $error("core not first in default scheme");

  // Default scheme: core beats DMA in a collision
  a_core_beats_dma: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && req[0] && req[1] && prio_r == DMBA_PRIO_DEFAULT)
    |=> grant == 3'h1)
    else $error("core lost to DMA in default");

  // Raised scheme: DMA outranks every other master
  a_dma_first: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && req[DMBA_REQ_DMA] && prio_r == DMBA_PRIO_DMA_RAISE)
    |=> grant == 3'h2)
    else $error("DMA not first in raised scheme");

  // Raised scheme: DMA beats core in a collision
  a_dma_raised: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && req[0] && req[1] && prio_r == DMBA_PRIO_DMA_RAISE)
    |=> grant == 3'h2)
    else $error("DMA not raised above core");

  // Raised scheme: core keeps slot one, above the debug master
  a_core_over_debug: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && req[0] && !req[1] && req[2] && prio_r == DMBA_PRIO_DMA_RAISE)
    |=> grant == 3'h1)
    else $error("core lost to debug master in raised scheme");

  // Debug master only wins an otherwise empty bus
  a_debug_lowest: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && req[2] && (req[0] || req[1]))
    |=> !grant[2])
    else $error("debug master won a collision");

  // DMA stays above the debug master in either scheme
  a_dma_over_debug: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == DMBA_IDLE && !req[0] && req[1] && req[2])
    |=> grant == 3'h2)
    else $error("DMA lost to debug master");

endmodule // dmba_arbiter

// *** dmba_req_model.sv ***
// Requester model: core, DMA and debug master on the data bus
`timescale 1ns/100ps
module dmba_req_model
  import dmba_pkg::*;
(
  input  wire logic [2:0] launch,
  input  wire logic [2:0] holdOff,
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] grant,
  output logic      [2:0] req,
  output logic      [2:0] accessDone
);
  // A stalled master keeps asking; holdOff stretches an access to act slowly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req        <= 3'h0;
      accessDone <= 3'h0;
    end else begin
      for (int i = 0; i < DMBA_N_REQ; i++) begin
        if (accessDone[i] && grant[i]) begin
          req[i]        <= 1'b0;
          accessDone[i] <= 1'b0;
        end else if (grant[i] && !holdOff[i]) begin
          accessDone[i] <= 1'b1; // Ends one cycle after grant
        end else if (launch[i]) begin
          req[i] <= 1'b1;
        end
      end
    end
  end
endmodule // dmba_req_model

// *** tb_data_memory_bus_arbiter.sv ***
// Testbench: priority order, stall and run-time priority change
`timescale 1ns/100ps
module tb_data_memory_bus_arbiter;
  import dmba_pkg::*;
  logic        clk, arst_n, prioWrite;
  logic [15:0] prioCtrl, prioActive;
  logic [2:0]  launch, holdOff, req, accessDone, grant, stall;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  dmba_arbiter u_dmba_arbiter (.clk(clk), .arst_n(arst_n), .prioCtrl(prioCtrl),
    .prioWrite(prioWrite), .req(req), .accessDone(accessDone), .grant(grant),
    .stall(stall), .prioActive(prioActive));
  dmba_req_model u_dmba_req_model (.launch(launch), .holdOff(holdOff), .clk(clk),
    .arst_n(arst_n), .grant(grant), .req(req), .accessDone(accessDone));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic set_prio(input logic [15:0] val);
    @(posedge clk);
    prioCtrl  <= val;
    prioWrite <= 1'b1;
    @(posedge clk);
    prioWrite <= 1'b0;
  endtask
  // Bounded wait until the bus is owned (busy) or free
  task automatic await_bus(input bit busy);
    for (int n = 0; n < 12 && ((grant !== 3'h0) != busy); n++) @(negedge clk);
  endtask
  task automatic kick(input logic [2:0] who);
    @(posedge clk);
    launch <= who;
    @(posedge clk);
    launch <= 3'h0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // All three collide; losers must stall until served in slot order
  task automatic order_scenario(input logic [2:0] o0, input logic [2:0] o1,
                                input logic [2:0] o2);
    logic [2:0] want [3];
    logic [2:0] left;
    want = '{o0, o1, o2};
    left = 3'h7;
    kick(3'h7);
    for (int k = 0; k < 3; k++) begin
      await_bus(1);
      chk("grant", {13'h0, want[k]}, {13'h0, grant});
      left = left & ~want[k];
      chk("stall", {13'h0, left}, {13'h0, stall});
      await_bus(0);
    end
  endtask
  // Reset must leave the bus free and the default scheme loaded
  task automatic reset_scenario();
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("prioActive", DMBA_PRIO_RESET, prioActive);
    chk("grant", 16'h0000, {13'h0, grant});
  endtask
  // Raising DMA while the core owns the bus must not cut the core off
  task automatic change_scenario();
    @(posedge clk);
    holdOff <= 3'h1;
    kick(3'h3);
    await_bus(1);
    set_prio(DMBA_PRIO_DMA_RAISE);
    repeat (2) @(negedge clk);
    chk("held grant", 16'h0001, {13'h0, grant});
    chk("held stall", 16'h0002, {13'h0, stall});
    chk("prioActive", DMBA_PRIO_DMA_RAISE, prioActive);
    @(posedge clk);
    holdOff <= 3'h0;
    await_bus(0);
    await_bus(1);
    chk("next grant", 16'h0002, {13'h0, grant});
    await_bus(0);
  endtask

  initial begin
    arst_n = 1'b0;
    prioCtrl = 16'h0000;
    prioWrite = 1'b0;
    launch = 3'h0;
    holdOff = 3'h0;
    reset_scenario();
    order_scenario(3'h1, 3'h2, 3'h4);
    change_scenario();
    order_scenario(3'h2, 3'h1, 3'h4);
    set_prio(DMBA_PRIO_DEFAULT);
    order_scenario(3'h1, 3'h2, 3'h4);
    wrap_up();
  end
endmodule // tb_data_memory_bus_arbiter
